// ---- design/pspc_pkg.sv ----
package pspc_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int POR_TIME_NS   = 250000;
    localparam int POR_CYCLES    = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NUM_REGS      = 32;
    localparam int NUM_SYNC      = 4;
    localparam int NUM_AUX       = 32;

    localparam logic [2:0] CHIP_ADDR = 3'h0;

    localparam logic [4:0] REG_IDENT      = 5'h00;
    localparam logic [4:0] REG_POWER      = 5'h01;
    localparam logic [4:0] REG_FRAC       = 5'h04;
    localparam logic [4:0] REG_VCO_ACCESS = 5'h05;
    localparam logic [4:0] REG_SEED       = 5'h06;
    localparam logic [4:0] REG_DRV_MASTER = 5'h08;
    localparam logic [4:0] REG_LEVEL      = 5'h0b;
    localparam logic [4:0] REG_PIN_CTRL   = 5'h0f;

    localparam int F_RD_ADDR_LSB = 0;
    localparam int F_RD_ADDR_MSB = 4;
    localparam int F_SOFT_RST    = 5;
    localparam int F_PIN_SEL     = 0;
    localparam int F_REG_PD      = 1;
    localparam int F_KEEP_LSB    = 2;
    localparam int F_KEEP_MSB    = 7;
    localparam int F_SEED_LSB    = 0;
    localparam int F_SEED_MSB    = 1;
    localparam int F_DRV_MASTER  = 5;
    localparam int F_LEVEL_3V3   = 22;
    localparam int F_AUX_SEL_LSB = 0;
    localparam int F_AUX_SEL_MSB = 4;
    localparam int F_AUTOMUX_DIS = 6;
    localparam int F_DRV_HOLD    = 7;
    localparam int F_PU_DIS      = 8;
    localparam int F_PD_DIS      = 9;

    localparam logic [23:0] DEF_ZERO       = 24'h000000;
    localparam logic [23:0] DEF_POWER      = 24'h000001;
    localparam logic [23:0] DEF_DRV_MASTER = 24'h000020;
    localparam logic [23:0] DEF_PIN_CTRL   = 24'h000001;

    // Start phases: zero, binary, random, all ones below the MSB
    localparam logic [3:0][23:0] SEED_PRESETS = {24'h7fffff, 24'h4c3b2a, 24'h800000, 24'h000000};

    typedef struct packed {
        logic [23:0] data;
        logic [4:0]  addr;
        logic [2:0]  chip;
    } pspc_frame_t;

    typedef enum logic {ST_POR, ST_RUN} pspc_state_t;
endpackage

// ---- design/pspc_top.sv ----
`timescale 1ns/1ps
// Overview of operation
// - Two-bit seed picks one of four start phases
// - Seed reloads on every fractional frequency write
// - Registers held at defaults for 250 us after reset
// - Soft reset clears registers, keeps serial mode
// - VCO access register survives soft reset
// - Enable pin low stops analog and clocks
// - Pin select clear: pin ignored, register bit controls power-down
// - Bits two to seven keep blocks alive
// - Shared driver tristated after reset except reads
// - Matching chip address enables the driver
// - Hold bit keeps driver on while both halves are enabled
// - Automux to read data unless disabled
// - Master enable cleared kills driver entirely
// - Pull-up, pull-down disables and 3.3 V select
// - Five-bit select picks aux output, default lock
// - Address zero reads the version identifier
// - Frame is 24 data, 5 address, 3 chip
// - Chip address for this device is zero
// - Frame commits on latch strobe rising edge
// - Serial out shifts the selected read register
module pspc_top #(
    parameter int          POR_CYCLES = pspc_pkg::POR_CYCLES,
    parameter logic [23:0] VERSION_ID = 24'h000a51  // Arbitrary value
) (
    input  wire logic        CLK_IN,
    input  wire logic        RESETN_IN,
    input  wire logic        SERIAL_CLOCK_IN,
    input  wire logic        SERIAL_IN_LINE_IN,
    input  wire logic        FRAME_LATCH_STROBE_IN,
    input  wire logic        CHIP_POWER_PIN_IN,
    input  wire logic [31:0] AUX_SOURCES_IN,
    output logic             SHARED_STATUS_OUT_PIN_OUT,
    output logic             SHARED_STATUS_OUT_PIN_OE_OUT,
    output logic             LEVEL_3V3_OUT,
    output logic             CLOCKS_ENABLE_OUT,
    output logic [5:0]       BLOCK_ENABLE_OUT,
    output logic [23:0]      PHASE_ACCUMULATOR_OUT,
    output logic             FRAC_LOAD_OUT,
    output logic             POR_DONE_OUT
);
    logic [pspc_pkg::NUM_SYNC-1:0] sync1_ff, sync2_ff, sync3_ff, stable_ff;
    logic [31:0]            shift_ff;
    logic [23:0]            regs_ff [pspc_pkg::NUM_REGS];
    logic [23:0]            out_shift_ff;
    logic                   soft_rst_ff, frac_wr_ff, load_ff, read_active_ff;
    logic [15:0]            por_cnt_ff;
    pspc_pkg::pspc_state_t  state_ff;

    wire [pspc_pkg::NUM_SYNC-1:0] raw_in = {CHIP_POWER_PIN_IN, FRAME_LATCH_STROBE_IN,
                                            SERIAL_IN_LINE_IN, SERIAL_CLOCK_IN};
    wire [pspc_pkg::NUM_SYNC-1:0] agree  = ~(sync2_ff ^ sync3_ff);
    wire [pspc_pkg::NUM_SYNC-1:0] rise   = agree & sync2_ff & ~stable_ff;
    wire [pspc_pkg::NUM_SYNC-1:0] fall   = agree & ~sync2_ff & stable_ff;

    wire sck_rise = rise[0];
    wire sck_fall = fall[0];
    wire sdi_bit  = stable_ff[1];
    wire sen_rise = rise[2];
    wire cen_lvl  = stable_ff[3];

    wire pspc_pkg::pspc_frame_t frame = pspc_pkg::pspc_frame_t'(shift_ff);
    wire por_busy = (state_ff == pspc_pkg::ST_POR);
    wire chip_hit = (frame.chip == pspc_pkg::CHIP_ADDR);
    wire commit   = sen_rise && chip_hit && !por_busy;

    wire [23:0] r_ident = regs_ff[pspc_pkg::REG_IDENT];
    wire [23:0] r_power = regs_ff[pspc_pkg::REG_POWER];
    wire [23:0] r_seed  = regs_ff[pspc_pkg::REG_SEED];
    wire [23:0] r_pin   = regs_ff[pspc_pkg::REG_PIN_CTRL];
    wire [4:0]  rd_addr = r_ident[pspc_pkg::F_RD_ADDR_MSB:pspc_pkg::F_RD_ADDR_LSB];
    wire [1:0]  seed_sel = r_seed[pspc_pkg::F_SEED_MSB:pspc_pkg::F_SEED_LSB];
    wire [4:0]  aux_sel  = r_pin[pspc_pkg::F_AUX_SEL_MSB:pspc_pkg::F_AUX_SEL_LSB];
    wire master_en   = regs_ff[pspc_pkg::REG_DRV_MASTER][pspc_pkg::F_DRV_MASTER];
    wire drv_hold    = r_pin[pspc_pkg::F_DRV_HOLD];
    wire automux_dis = r_pin[pspc_pkg::F_AUTOMUX_DIS];
    wire pu_dis      = r_pin[pspc_pkg::F_PU_DIS];
    wire pd_dis      = r_pin[pspc_pkg::F_PD_DIS];
    wire pin_sel     = r_power[pspc_pkg::F_PIN_SEL];

    // Address zero answers with the version, not the stored read pointer
    wire [23:0] rd_data = (rd_addr == pspc_pkg::REG_IDENT) ? VERSION_ID : regs_ff[rd_addr];

    wire power_down = pin_sel ? !cen_lvl : r_power[pspc_pkg::F_REG_PD];
    wire [5:0] keep = r_power[pspc_pkg::F_KEEP_MSB:pspc_pkg::F_KEEP_LSB];
    wire aux_bit = AUX_SOURCES_IN[aux_sel];
    wire use_sdo = read_active_ff && !automux_dis;
    wire pin_val = use_sdo ? out_shift_ff[23] : aux_bit;
    // Push-pull: a disabled half simply releases the pin for that level
    wire half_off = pin_val ? pu_dis : pd_dis;
    wire drive = master_en && (drv_hold || read_active_ff) && !half_off;

    // Three-stage sampling; only the agreed level counts as a change
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            sync1_ff  <= '0;
            sync2_ff  <= '0;
            sync3_ff  <= '0;
            stable_ff <= '0;
        end else begin
            sync1_ff  <= raw_in;
            sync2_ff  <= sync1_ff;
            sync3_ff  <= sync2_ff;
            stable_ff <= (agree & sync2_ff) | (~agree & stable_ff);
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            state_ff   <= pspc_pkg::ST_POR;
            por_cnt_ff <= 16'h0000;
        end else begin
            case (state_ff)
                pspc_pkg::ST_POR: begin
                    por_cnt_ff <= por_cnt_ff + 16'h0001;
                    if (por_cnt_ff == 16'(POR_CYCLES - 1)) begin
                        state_ff <= pspc_pkg::ST_RUN;
                    end
                end
                pspc_pkg::ST_RUN: state_ff <= pspc_pkg::ST_RUN;
                default: state_ff <= pspc_pkg::ST_POR;
            endcase
        end
    end

    // Frame shifter, MSB first on rising serial clock
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            shift_ff <= 32'h00000000;
        end else if (sck_rise) begin
            shift_ff <= {shift_ff[30:0], sdi_bit};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < pspc_pkg::NUM_REGS; gi++) begin : g_reg
            localparam logic [4:0] IDX = 5'(gi);
            localparam logic [23:0] DEF =
                (IDX == pspc_pkg::REG_POWER)      ? pspc_pkg::DEF_POWER :
                (IDX == pspc_pkg::REG_DRV_MASTER) ? pspc_pkg::DEF_DRV_MASTER :
                (IDX == pspc_pkg::REG_PIN_CTRL)   ? pspc_pkg::DEF_PIN_CTRL : pspc_pkg::DEF_ZERO;
            localparam bit VCO = (IDX == pspc_pkg::REG_VCO_ACCESS);
            wire wr  = commit && (frame.addr == IDX);
            wire clr = por_busy || (soft_rst_ff && !VCO);
            always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
                if (!RESETN_IN) begin
                    regs_ff[gi] <= DEF;
                end else if (clr) begin
                    regs_ff[gi] <= DEF;
                end else if (wr) begin
                    regs_ff[gi] <= frame.data;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            soft_rst_ff <= 1'b0;
            frac_wr_ff  <= 1'b0;
            load_ff     <= 1'b0;
        end else begin
            soft_rst_ff <= commit && frame.addr == pspc_pkg::REG_IDENT
                           && frame.data[pspc_pkg::F_SOFT_RST];
            frac_wr_ff  <= commit && frame.addr == pspc_pkg::REG_FRAC;
            load_ff     <= sen_rise;
        end
    end

    // Read window: opened by a pointer write, closed by the next strobe
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            read_active_ff <= 1'b0;
        end else if (sen_rise) begin
            read_active_ff <= commit && frame.addr == pspc_pkg::REG_IDENT
                              && !read_active_ff;
        end
    end

    // Loaded a cycle after the strobe so the new pointer is already stored
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            out_shift_ff <= 24'h000000;
        end else if (load_ff) begin
            out_shift_ff <= rd_data;
        end else if (sck_fall) begin
            out_shift_ff <= {out_shift_ff[22:0], 1'b0};
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            PHASE_ACCUMULATOR_OUT <= pspc_pkg::SEED_PRESETS[0];
            FRAC_LOAD_OUT         <= 1'b0;
        end else begin
            FRAC_LOAD_OUT <= frac_wr_ff;
            if (frac_wr_ff) begin
                PHASE_ACCUMULATOR_OUT <= pspc_pkg::SEED_PRESETS[seed_sel];
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            SHARED_STATUS_OUT_PIN_OUT    <= 1'b0;
            SHARED_STATUS_OUT_PIN_OE_OUT <= 1'b0;
            LEVEL_3V3_OUT                <= 1'b0;
            CLOCKS_ENABLE_OUT            <= 1'b0;
            BLOCK_ENABLE_OUT             <= 6'h00;
            POR_DONE_OUT                 <= 1'b0;
        end else begin
            SHARED_STATUS_OUT_PIN_OUT    <= pin_val;
            SHARED_STATUS_OUT_PIN_OE_OUT <= drive;
            LEVEL_3V3_OUT                <= regs_ff[pspc_pkg::REG_LEVEL][pspc_pkg::F_LEVEL_3V3];
            CLOCKS_ENABLE_OUT            <= !power_down;
            BLOCK_ENABLE_OUT             <= {6{!power_down}} | keep;
            POR_DONE_OUT                 <= !por_busy;
        end
    end

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    chk_frame_commit: assert property (
        commit && frame.addr == pspc_pkg::REG_POWER |=> r_power == $past(frame.data))
        else $error("power register did not take committed frame");
    chk_chip_mismatch: assert property (
        sen_rise && !chip_hit && !soft_rst_ff && !por_busy |=> $stable(r_power))
        else $error("frame with foreign chip address changed a register");
    chk_soft_reset: assert property (
        soft_rst_ff |=> r_pin == pspc_pkg::DEF_PIN_CTRL && r_power == pspc_pkg::DEF_POWER)
        else $error("soft reset did not restore defaults");
    chk_vco_keep: assert property (
        soft_rst_ff |=> $stable(regs_ff[pspc_pkg::REG_VCO_ACCESS]))
        else $error("soft reset disturbed the VCO access register");
    chk_seed_reload: assert property (
        frac_wr_ff |=> PHASE_ACCUMULATOR_OUT == pspc_pkg::SEED_PRESETS[$past(seed_sel)] && FRAC_LOAD_OUT)
        else $error("seed not reloaded on fractional write");
    chk_master_off: assert property (
        !master_en |=> !SHARED_STATUS_OUT_PIN_OE_OUT)
        else $error("driver on while master enable cleared");
    chk_hold_drive: assert property (
        master_en && drv_hold && !pu_dis && !pd_dis |=> SHARED_STATUS_OUT_PIN_OE_OUT)
        else $error("hold bit did not keep driver on");
    chk_pin_power: assert property (
        pin_sel && !cen_lvl |=> !CLOCKS_ENABLE_OUT && BLOCK_ENABLE_OUT == $past(keep))
        else $error("enable pin low did not power down");
    chk_reg_power: assert property (
        !pin_sel |=> CLOCKS_ENABLE_OUT == !$past(r_power[pspc_pkg::F_REG_PD]))
        else $error("register power-down bit not followed");
    chk_por_length: assert property (
        $rose(state_ff == pspc_pkg::ST_RUN) |-> por_cnt_ff == 16'(POR_CYCLES))
        else $error("power-on settle length wrong");
    chk_aux_select: assert property (
        !use_sdo |=> SHARED_STATUS_OUT_PIN_OUT == $past(aux_bit))
        else $error("aux output not the selected source");
endmodule

// ---- test/pspc_host_model.sv ----
`timescale 1ns/1ps
module pspc_host_model (
    input  wire logic clk_in,
    input  wire logic pin_in,
    input  wire logic oe_in,
    output logic      sclk_out,
    output logic      sdata_out,
    output logic      strobe_out
);
    initial begin
        sclk_out   = 1'b0;
        sdata_out  = 1'b0;
        strobe_out = 1'b0;
    end

    // Clock idles low; phase offset keeps it unrelated to the system clock
    task automatic xfer(input pspc_pkg::pspc_frame_t f, output logic [23:0] rd);
        logic [31:0] bits;
        bits = f;
        rd = 24'h000000;
        @(posedge clk_in);
        #13;
        for (int i = 31; i >= 0; i--) begin
            sdata_out = bits[i];
            #160;
            sclk_out = 1'b1;
            #150;
            if (i >= 8) rd[i - 8] = oe_in ? pin_in : 1'bx;
            #10;
            sclk_out = 1'b0;
        end
        // Released line shows the inverse, so stale bits never match
        sdata_out = ~bits[0];
        #160;
        strobe_out = 1'b1;
        #320;
        strobe_out = 1'b0;
        #320;
    endtask
endmodule

// ---- test/pspc_top_tb.sv ----
`timescale 1ns/1ps
module pspc_top_tb;
    localparam logic [23:0] VER = 24'h000a51;  // Arbitrary value
    logic        clk, resetn, sclk, sdata, strobe, pwr_pin, pin, oe;
    logic        lvl, clk_en, frac_ld, por_done;
    logic [31:0] aux;
    logic [5:0]  blk_en;
    logic [23:0] phase, d;
    int          n_ld = 0;
    int          n_mismatch = 0;
    int          tests_run = 0;

    pspc_top #(.POR_CYCLES(20), .VERSION_ID(VER)) u_pspc_top (
        .CLK_IN                       (clk),
        .RESETN_IN                    (resetn),
        .SERIAL_CLOCK_IN              (sclk),
        .SERIAL_IN_LINE_IN            (sdata),
        .FRAME_LATCH_STROBE_IN        (strobe),
        .CHIP_POWER_PIN_IN            (pwr_pin),
        .AUX_SOURCES_IN               (aux),
        .SHARED_STATUS_OUT_PIN_OUT    (pin),
        .SHARED_STATUS_OUT_PIN_OE_OUT (oe),
        .LEVEL_3V3_OUT                (lvl),
        .CLOCKS_ENABLE_OUT            (clk_en),
        .BLOCK_ENABLE_OUT             (blk_en),
        .PHASE_ACCUMULATOR_OUT        (phase),
        .FRAC_LOAD_OUT                (frac_ld),
        .POR_DONE_OUT                 (por_done)
    );
    pspc_host_model u_pspc_host_model (.clk_in(clk), .pin_in(pin), .oe_in(oe),
        .sclk_out(sclk), .sdata_out(sdata), .strobe_out(strobe));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (frac_ld === 1'b1) n_ld <= n_ld + 1;
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [23:0] v, input logic [2:0] c = 3'h0);
        logic [23:0] unused;
        u_pspc_host_model.xfer('{data: v, addr: a, chip: c}, unused);
    endtask

    // Two frames: point, then shift out; the second strobe closes the window
    task automatic rd(input logic [4:0] a, output logic [23:0] v);
        wr(pspc_pkg::REG_IDENT, {19'h00000, a});
        u_pspc_host_model.xfer('{data: {19'h00000, a}, addr: 5'h00, chip: 3'h0}, v);
    endtask

    task automatic t_por;
        int n;
        n = 0;
        while (por_done !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(24'(n), 24'h000015);
        chk(24'(oe), 24'h000000);
        wr(pspc_pkg::REG_IDENT, 24'h000020);
        // Pointer write opened the window; this frame reads it and closes it
        u_pspc_host_model.xfer('{data: 24'h000000, addr: 5'h00, chip: 3'h0}, d);
        chk(d, VER);
        rd(pspc_pkg::REG_POWER, d);
        chk(d, 24'h000001);
        rd(pspc_pkg::REG_DRV_MASTER, d);
        chk(d, 24'h000020);
        rd(pspc_pkg::REG_PIN_CTRL, d);
        chk(d, 24'h000001);
        rd(pspc_pkg::REG_IDENT, d);
        chk(d, VER);
        chk(24'(oe), 24'h000000);
        $display("t_por done");
    endtask

    task automatic t_chip;
        wr(pspc_pkg::REG_SEED, 24'h000003, 3'h1);
        chk(24'(oe), 24'h000000);
        rd(pspc_pkg::REG_SEED, d);
        chk(d, 24'h000000);
        wr(pspc_pkg::REG_SEED, 24'h000001);
        rd(pspc_pkg::REG_SEED, d);
        chk(d, 24'h000001);
        $display("t_chip done");
    endtask

    task automatic t_seed;
        logic [1:0] sel [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
        int n0;
        for (int i = 0; i < 4; i++) begin
            wr(pspc_pkg::REG_SEED, {22'h000000, sel[i]});
            n0 = n_ld;
            wr(pspc_pkg::REG_FRAC, 24'h938000);
            chk(phase, pspc_pkg::SEED_PRESETS[sel[i]]);
            chk(24'(n_ld - n0), 24'h000001);
        end
        $display("t_seed done");
    endtask

    task automatic t_power;
        wr(pspc_pkg::REG_VCO_ACCESS, 24'h000000);
        pwr_pin = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk(24'({clk_en, blk_en}), 24'h000000);
        rd(pspc_pkg::REG_POWER, d);
        chk(d, 24'h000001);
        wr(pspc_pkg::REG_POWER, 24'h0000a8);
        chk(24'({clk_en, blk_en}), 24'h00007f);
        wr(pspc_pkg::REG_POWER, 24'h0000aa);
        chk(24'({clk_en, blk_en}), 24'h00002a);
        wr(pspc_pkg::REG_POWER, 24'h000001);
        pwr_pin = 1'b1;
        wr(pspc_pkg::REG_VCO_ACCESS, 24'h123456);
        wr(pspc_pkg::REG_IDENT, 24'h000020);
        u_pspc_host_model.xfer('{data: 24'h000000, addr: 5'h00, chip: 3'h0}, d);
        chk(d, VER);
        rd(pspc_pkg::REG_VCO_ACCESS, d);
        chk(d, 24'h123456);
        rd(pspc_pkg::REG_SEED, d);
        chk(d, 24'h000000);
        $display("t_power done");
    endtask

    task automatic t_drv;
        logic [30:0] tbl [5] = '{{5'h0f, 24'h000080, 2'b10}, {5'h0f, 24'h000081, 2'b11},
            {5'h0f, 24'h000181, 2'b00}, {5'h0f, 24'h000281, 2'b11}, {5'h08, 24'h000000, 2'b00}};
        for (int i = 0; i < 5; i++) begin
            wr(tbl[i][30:26], tbl[i][25:2]);
            chk(24'(oe), 24'(tbl[i][1]));
            if (tbl[i][1]) chk(24'(pin), 24'(tbl[i][0]));
        end
        wr(pspc_pkg::REG_DRV_MASTER, 24'h000020);
        wr(pspc_pkg::REG_PIN_CTRL, 24'h0000c1);
        rd(pspc_pkg::REG_PIN_CTRL, d);
        chk(d, 24'hffffff);
        wr(pspc_pkg::REG_LEVEL, 24'h400000);
        chk(24'(lvl), 24'h000001);
        $display("t_drv done");
    endtask

    task automatic end_of_test;
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    initial begin
        resetn = 1'b0;
        pwr_pin = 1'b1;
        aux = 32'h00000002;
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
        t_por();
        t_chip();
        t_seed();
        t_power();
        t_drv();
        end_of_test();
    end

    // About fifty frames of 11 us each; twice that as margin
    initial begin
        #1200000;
        n_mismatch++;
        end_of_test();
    end
endmodule
